// ---- verilog/flash_op_timing_reset_dpd.sv ----
// flash operation timing, reset abort and deep power-down control
`timescale 1ns/1ps
module flash_op_timing_reset_dpd (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // flash control pins
  input wire logic reset_pin_n,
  input wire logic deep_sleep_pin,
  input wire logic sleep_pin_polarity_bit,
  input wire logic chip_sel_n,
  // command interface, latched by the bus front end without needing the bus clock
  input wire flash_seq_pkg::cmd_type cmd,
  // status
  output flash_seq_pkg::status_type status,
  output logic wake_ok
);
  // full state of the module
  typedef struct packed {
    flash_seq_pkg::state_type st;
    flash_seq_pkg::op_type op;
    logic [24:0] cnt;
    logic [24:0] saved;
    logic first_done;
    logic [11:0] wake;
    flash_seq_pkg::status_type stat;
    logic wake_ok;
  } regs_type;

  regs_type r;
  regs_type next_r;
  logic sleep_active;

  // duration of an operation in cycles
  function automatic logic [24:0] op_cycles(input flash_seq_pkg::op_type op,
                                            input logic first_done,
                                            input logic new_process);
    logic [24:0] c;
    c = 25'(flash_seq_pkg::BLANK_CYC);
    unique case (op)
      flash_seq_pkg::OP_WORD: c = first_done ? 25'(flash_seq_pkg::WORD_NEXT_CYC)
                                             : 25'(flash_seq_pkg::WORD_FIRST_CYC);
      flash_seq_pkg::OP_BUFFER: c = new_process ? 25'(flash_seq_pkg::BUF_NEW_CYC)
                                                : 25'(flash_seq_pkg::BUF_OLD_CYC);
      flash_seq_pkg::OP_ERASE: c = 25'(flash_seq_pkg::ERASE_TYP_CYC);
      default: c = 25'(flash_seq_pkg::BLANK_CYC);
    endcase
    return c;
  endfunction : op_cycles

  // sleep pin level decode, polarity bit selects the active level
  assign sleep_active = sleep_pin_polarity_bit ? deep_sleep_pin : !deep_sleep_pin;

  // next state logic
  always_comb
  begin
    next_r = r;
    next_r.stat.done = 1'b0;
    if (r.cnt != flash_seq_pkg::CNT_ZERO)
    begin
      next_r.cnt = r.cnt - 25'h0000001;
    end
    if (r.wake != 12'h000)
    begin
      next_r.wake = r.wake - 12'h001;
    end
    next_r.wake_ok = (r.st != flash_seq_pkg::ST_SLEEP) && (r.st != flash_seq_pkg::ST_RESET)
                     && (r.wake == 12'h000);
    if (!reset_pin_n)
    begin
      // reset entry: floats outputs and stops work
      next_r.stat.outputs_off = 1'b1;
      next_r.stat.ready = 1'b0;
      next_r.stat.suspended = 1'b0;
      next_r.stat.asleep = 1'b0;
      next_r.first_done = 1'b0;
      if (r.st == flash_seq_pkg::ST_RUN || r.st == flash_seq_pkg::ST_SUSPENDING)
      begin
        next_r.st = flash_seq_pkg::ST_ABORT;
        next_r.cnt = 25'(flash_seq_pkg::ABORT_CYC);
        next_r.stat.aborted = 1'b1;
      end
      else if (r.st != flash_seq_pkg::ST_ABORT)
      begin
        next_r.st = flash_seq_pkg::ST_RESET;
        next_r.cnt = flash_seq_pkg::CNT_ZERO;
      end
      else if (r.cnt == flash_seq_pkg::CNT_ZERO)
      begin
        next_r.st = flash_seq_pkg::ST_RESET;
      end
      // wake wait is held full while reset is low, so it runs from release
      if (r.st == flash_seq_pkg::ST_SLEEP || r.wake != 12'h000)
      begin
        next_r.wake = 12'(flash_seq_pkg::WAKE_CYC);
      end
    end
    else
    begin
      unique case (r.st)
        flash_seq_pkg::ST_ABORT, flash_seq_pkg::ST_RESET:
        begin
          next_r.st = flash_seq_pkg::ST_IDLE;
          next_r.stat.outputs_off = 1'b0;
          next_r.stat.ready = 1'b1;
        end
        flash_seq_pkg::ST_IDLE:
        begin
          if (sleep_active && chip_sel_n)
          begin
            next_r.st = flash_seq_pkg::ST_SLEEP;
            next_r.stat.asleep = 1'b1;
            next_r.stat.outputs_off = 1'b1;
          end
          else if (cmd.valid && cmd.op <= flash_seq_pkg::OP_BLANK)
          begin
            // operation command accepted in idle unless sleep entry wins, bus clock not needed
            next_r.st = flash_seq_pkg::ST_RUN;
            next_r.op = cmd.op;
            next_r.cnt = op_cycles(cmd.op, r.first_done, cmd.new_process);
            next_r.stat.ready = 1'b0;
            next_r.stat.aborted = 1'b0;
          end
        end
        flash_seq_pkg::ST_RUN:
        begin
          if (cmd.valid && cmd.op == flash_seq_pkg::OP_SUSPEND)
          begin
            next_r.st = flash_seq_pkg::ST_SUSPENDING;
            next_r.saved = r.cnt;
            next_r.cnt = 25'(flash_seq_pkg::SUSPEND_CYC);
          end
          else if (r.cnt == flash_seq_pkg::CNT_ZERO)
          begin
            next_r.st = flash_seq_pkg::ST_IDLE;
            next_r.stat.ready = 1'b1;
            next_r.stat.done = 1'b1;
            next_r.stat.blank_ok = (r.op == flash_seq_pkg::OP_BLANK);
            next_r.first_done = (r.op == flash_seq_pkg::OP_WORD);
          end
        end
        flash_seq_pkg::ST_SUSPENDING:
        begin
          if (r.cnt == flash_seq_pkg::CNT_ZERO)
          begin
            next_r.st = flash_seq_pkg::ST_SUSPENDED;
            next_r.stat.suspended = 1'b1;
            next_r.stat.ready = 1'b1;
          end
        end
        flash_seq_pkg::ST_SUSPENDED:
        begin
          if (cmd.valid && cmd.op == flash_seq_pkg::OP_RESUME)
          begin
            next_r.st = flash_seq_pkg::ST_RUN;
            next_r.cnt = r.saved;
            next_r.stat.suspended = 1'b0;
            next_r.stat.ready = 1'b0;
          end
        end
        flash_seq_pkg::ST_SLEEP:
        begin
          if (!sleep_active)
          begin
            next_r.st = flash_seq_pkg::ST_IDLE;
            next_r.stat.asleep = 1'b0;
            next_r.stat.outputs_off = 1'b0;
            next_r.wake = 12'(flash_seq_pkg::WAKE_CYC);
          end
        end
        default:
        begin
          next_r.st = flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '{st: flash_seq_pkg::ST_IDLE,
             op: flash_seq_pkg::OP_WORD, cnt: 25'h0000000, saved: 25'h0000000,
             first_done: 1'b0, wake: 12'h000,
             stat: '{ready: 1'b1, default: 1'b0}, wake_ok: 1'b1};
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign status = r.stat;
  assign wake_ok = r.wake_ok;

  // reset with nothing running completes in the least pulse
  property p_reset_quick;
    @(posedge clock) disable iff (!rstn)
      (!reset_pin_n && r.st == flash_seq_pkg::ST_IDLE) |=> ##[0:1] r.st == flash_seq_pkg::ST_RESET;
  endproperty
  a_reset_quick: assert property (p_reset_quick) else $error("reset not reached");

  // reset during a run aborts it within the bound
  property p_abort;
    @(posedge clock) disable iff (!rstn)
      (!reset_pin_n && r.st == flash_seq_pkg::ST_RUN)
      |-> ##[1:20] (r.st == flash_seq_pkg::ST_RESET || reset_pin_n);
  endproperty
  a_abort: assert property (p_abort) else $error("abort too slow");

  // reset floats the outputs
  property p_outputs_off;
    @(posedge clock) disable iff (!rstn) !reset_pin_n |=> status.outputs_off;
  endproperty
  a_outputs_off: assert property (p_outputs_off) else $error("outputs not off in reset");

  // busy while running
  property p_busy;
    @(posedge clock) disable iff (!rstn) r.st == flash_seq_pkg::ST_RUN |-> !status.ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while running");

  // suspend reaches suspended state within bound
  property p_suspend;
    @(posedge clock) disable iff (!rstn)
      (r.st == flash_seq_pkg::ST_RUN && cmd.valid && cmd.op == flash_seq_pkg::OP_SUSPEND
       && reset_pin_n) ##1 reset_pin_n[*8] |-> ##[0:600] status.suspended || !reset_pin_n;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend too slow");

  // sleep entered only with active pin level and chip select high
  property p_sleep_entry;
    @(posedge clock) disable iff (!rstn)
      $rose(status.asleep) |-> $past(sleep_active) && $past(chip_sel_n);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry");

  // polarity cleared gives active low pin
  property p_polarity;
    @(posedge clock) disable iff (!rstn)
      (r.st == flash_seq_pkg::ST_IDLE && !sleep_pin_polarity_bit && !deep_sleep_pin
       && chip_sel_n && reset_pin_n) |=> status.asleep;
  endproperty
  a_polarity: assert property (p_polarity) else $error("low pin did not sleep");

  // word program count stays within the first-word time
  property p_word_done;
    @(posedge clock) disable iff (!rstn)
      (r.st == flash_seq_pkg::ST_RUN && r.op == flash_seq_pkg::OP_WORD)
      |-> r.cnt <= 25'(flash_seq_pkg::WORD_FIRST_CYC);
  endproperty
  a_word_done: assert property (p_word_done) else $error("word time over bound");
endmodule : flash_op_timing_reset_dpd

// ---- verilog/flash_seq_pkg.sv ----
// package: timing constants, operation codes and state carriers for the flash sequencer
package flash_seq_pkg;
  // clock rate
  localparam int unsigned CLOCK_HZ = 20000000;
  localparam int unsigned CLOCK_NS = 50;
  // operation times in their own units
  localparam int unsigned WORD_FIRST_US = 115;
  localparam int unsigned WORD_NEXT_US = 50;
  localparam int unsigned WORD_MAX_US = 230;
  localparam int unsigned BUF_WORDS = 512;
  localparam int unsigned BUF_OLD_US = 4300;
  localparam int unsigned BUF_NEW_US = 2050;
  localparam int unsigned ERASE_TYP_MS = 900;
  localparam int unsigned ERASE_MAX_MS = 4000;
  localparam int unsigned SUSPEND_TYP_US = 20;
  localparam int unsigned SUSPEND_MAX_US = 30;
  localparam int unsigned BLANK_TYP_US = 3200;
  localparam int unsigned ABORT_MAX_US = 25;
  localparam int unsigned RESET_MIN_NS = 100;
  localparam int unsigned SLEEP_MIN_NS = 100;
  localparam int unsigned WAKE_MIN_US = 75;
  // cycle counts, long times round down, least times round up
  localparam int unsigned CYC_PER_US = CLOCK_HZ / 1000000;
  localparam longint unsigned WORD_FIRST_CYC = longint'(WORD_FIRST_US) * CYC_PER_US;
  localparam longint unsigned WORD_NEXT_CYC = longint'(WORD_NEXT_US) * CYC_PER_US;
  localparam longint unsigned BUF_OLD_CYC = longint'(BUF_OLD_US) * CYC_PER_US;
  localparam longint unsigned BUF_NEW_CYC = longint'(BUF_NEW_US) * CYC_PER_US;
  localparam longint unsigned ERASE_TYP_CYC = longint'(ERASE_TYP_MS) * 1000 * CYC_PER_US;
  localparam longint unsigned BLANK_CYC = longint'(BLANK_TYP_US) * CYC_PER_US;
  localparam int unsigned SUSPEND_CYC = SUSPEND_TYP_US * CYC_PER_US;
  localparam int unsigned ABORT_CYC = 16;
  localparam int unsigned RESET_CYC = (RESET_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int unsigned WAKE_CYC = WAKE_MIN_US * CYC_PER_US;
  // counter width covers the erase time
  localparam int unsigned CNT_W = 25;
  localparam logic [24:0] CNT_ZERO = 25'h0000000;
  // operation codes
  typedef enum logic [2:0] {
    OP_WORD = 3'h0,
    OP_BUFFER = 3'h1,
    OP_ERASE = 3'h2,
    OP_BLANK = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESUME = 3'h5
  } op_type;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_SUSPENDING,
    ST_SUSPENDED,
    ST_ABORT,
    ST_RESET,
    ST_SLEEP
  } state_type;
  // command from the bus interface
  typedef struct packed {
    logic valid;
    op_type op;
    logic new_process;
  } cmd_type;
  // status back to the bus interface
  typedef struct packed {
    logic ready;
    logic suspended;
    logic done;
    logic blank_ok;
    logic aborted;
    logic asleep;
    logic outputs_off;
  } status_type;
endpackage : flash_seq_pkg

// ---- dv/flash_host_model.sv ----
// host controller model: reset, deep sleep, polarity and chip select pins
`timescale 1ns/1ps
module flash_host_model (
  // clock
  input wire logic clock,
  // flash control pins
  output logic reset_pin_n,
  output logic deep_sleep_pin,
  output logic sleep_pin_polarity_bit,
  output logic chip_sel_n
);
  int held;
  int since_wake;
  logic sleeping;
  // pins start idle: out of reset, awake, active-low sleep pin, deselected
  initial
  begin
    reset_pin_n = 1'b1;
    deep_sleep_pin = 1'b1;
    sleep_pin_polarity_bit = 1'b0;
    chip_sel_n = 1'b1;
    held = 0;
    sleeping = 1'b0;
    since_wake = flash_seq_pkg::WAKE_CYC;
  end
  // cycles spent in the present pin state and since the last wake
  always @(posedge clock)
  begin
    held <= held + 1;
    since_wake <= since_wake + 1;
  end
  // pick the sleep pin level, parking the pin at its new idle level
  task configure(input logic pol);
    @(negedge clock);
    sleep_pin_polarity_bit = pol;
    deep_sleep_pin = ~pol;
  endtask : configure
  task reset_low;
    @(negedge clock);
    reset_pin_n = 1'b0;
    held = 0;
  endtask : reset_low
  // release only after the least pulse width
  task reset_high;
    while (held < flash_seq_pkg::RESET_CYC) @(negedge clock);
    reset_pin_n = 1'b1;
    if (sleeping) since_wake = 0;
  endtask : reset_high
  // deselect no later than the sleep pin goes active
  task sleep_enter;
    @(negedge clock);
    chip_sel_n = 1'b1;
    deep_sleep_pin = sleep_pin_polarity_bit;
    held = 0;
    sleeping = 1'b1;
  endtask : sleep_enter
  task sleep_exit;
    while (held < 2) @(negedge clock);
    deep_sleep_pin = ~sleep_pin_polarity_bit;
    since_wake = 0;
    sleeping = 1'b0;
  endtask : sleep_exit
  // select only once the wake time has run out
  task select;
    while (since_wake < flash_seq_pkg::WAKE_CYC) @(negedge clock);
    chip_sel_n = 1'b0;
  endtask : select
  task deselect;
    @(negedge clock);
    chip_sel_n = 1'b1;
  endtask : deselect
endmodule : flash_host_model

// ---- dv/flash_op_timing_reset_dpd_tb.sv ----
// self-checking bench for operation timing, reset abort and deep sleep
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module flash_op_timing_reset_dpd_tb;
  typedef struct {flash_seq_pkg::op_type op; logic np; int t;} row_type;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  flash_seq_pkg::cmd_type cmd = '0;
  flash_seq_pkg::status_type status;
  logic wake_ok, reset_pin_n, deep_sleep_pin, sleep_pin_polarity_bit, chip_sel_n;
  logic [3:0] sigs;
  int bad_count = 0;
  int n_checks = 0;
  int n;
  row_type rows [3];
  assign sigs = {wake_ok, status.ready, status.suspended, status.done};
  // 20 MHz clock
  always #25 clock = ~clock;
  flash_op_timing_reset_dpd i_flash_op_timing_reset_dpd (
    .clock(clock), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .deep_sleep_pin(deep_sleep_pin), .sleep_pin_polarity_bit(sleep_pin_polarity_bit),
    .chip_sel_n(chip_sel_n), .cmd(cmd), .status(status), .wake_ok(wake_ok));
  flash_host_model i_flash_host_model (
    .clock(clock), .reset_pin_n(reset_pin_n), .deep_sleep_pin(deep_sleep_pin),
    .sleep_pin_polarity_bit(sleep_pin_polarity_bit), .chip_sel_n(chip_sel_n));
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // hold a command for one cycle
  task launch(input flash_seq_pkg::op_type op, input logic np);
    cmd = '{1'b1, op, np};
    @(negedge clock);
    cmd = '0;
  endtask : launch
  // count falling edges until the chosen status bit is high, bounded
  task wait_sig(input int which, input int lim);
    n = 0;
    while (sigs[which] !== 1'b1)
    begin
      @(negedge clock);
      n++;
      if (n > lim)
      begin
        bad_count++;
        $display("BAD wait %0d expected 1 seen 0", which);
        conclude();
      end
    end
  endtask : wait_sig
  initial
  begin
    rows[0] = '{flash_seq_pkg::OP_WORD, 1'b0, int'(flash_seq_pkg::WORD_FIRST_CYC)};
    rows[1] = '{flash_seq_pkg::OP_WORD, 1'b0, int'(flash_seq_pkg::WORD_NEXT_CYC)};
    rows[2] = '{flash_seq_pkg::OP_BUFFER, 1'b1, int'(flash_seq_pkg::BUF_NEW_CYC)};
    repeat (2) @(negedge clock);
    `CHK("reset_state", 8'h81, {status, wake_ok})
    rstn = 1'b1;
    @(negedge clock);
    // ordinary operations: busy, then done within the timed window
    foreach (rows[i])
    begin
      launch(rows[i].op, rows[i].np);
      @(negedge clock);
      `CHK("busy", 1'b0, status.ready)
      wait_sig(0, rows[i].t + 10);
      `CHK("op_cycles", 1'b1, n >= rows[i].t - 3 && n <= rows[i].t + 4)
      @(negedge clock);
      `CHK("ready_after", 1'b1, status.ready)
    end
    // suspend while idle is ignored
    launch(flash_seq_pkg::OP_SUSPEND, 1'b0);
    repeat (3) @(negedge clock);
    `CHK("idle_suspend", 2'b10, {status.ready, status.suspended})
    // erase, suspend, resume
    launch(flash_seq_pkg::OP_ERASE, 1'b0);
    @(negedge clock);
    `CHK("erase_busy", 1'b0, status.ready)
    launch(flash_seq_pkg::OP_SUSPEND, 1'b0);
    wait_sig(1, 700);
    `CHK("susp_cycles", 1'b1, n >= flash_seq_pkg::SUSPEND_CYC - 3 && n <= 600)
    `CHK("susp_ready", 1'b1, status.ready)
    @(negedge clock);
    launch(flash_seq_pkg::OP_RESUME, 1'b0);
    @(negedge clock);
    `CHK("resumed", 2'b00, {status.ready, status.suspended})
    // reset pin during erase aborts it
    i_flash_host_model.reset_low();
    repeat (2) @(negedge clock);
    `CHK("abort_flags", 2'b11, {status.aborted, status.outputs_off})
    repeat (20) @(negedge clock);
    i_flash_host_model.reset_high();
    wait_sig(2, 470);
    @(negedge clock);
    `CHK("abort_end", 2'b10, {status.ready, status.outputs_off})
    // reset with nothing running
    i_flash_host_model.reset_low();
    @(negedge clock);
    `CHK("idle_off", 1'b1, status.outputs_off)
    i_flash_host_model.reset_high();
    repeat (2) @(negedge clock);
    `CHK("idle_reset", 2'b10, {status.ready, status.outputs_off})
    // blank check runs busy, then a short reset pulse cuts it
    launch(flash_seq_pkg::OP_BLANK, 1'b0);
    @(negedge clock);
    `CHK("blank_busy", 2'b00, {status.ready, status.blank_ok})
    i_flash_host_model.reset_low();
    i_flash_host_model.reset_high();
    wait_sig(2, 40);
    @(negedge clock);
    `CHK("blank_cut", 2'b11, {status.ready, status.aborted})
    // deep sleep with both pin polarities
    for (int p = 0; p < 2; p++)
    begin
      i_flash_host_model.configure(p[0]);
      i_flash_host_model.sleep_enter();
      repeat (2) @(negedge clock);
      `CHK("asleep", 2'b10, {status.asleep, wake_ok})
      i_flash_host_model.sleep_exit();
      @(negedge clock);
      `CHK("woken", 2'b00, {status.asleep, wake_ok})
      wait_sig(3, flash_seq_pkg::WAKE_CYC + 10);
      `CHK("wake_cycles", 1'b1, n >= flash_seq_pkg::WAKE_CYC - 3)
      i_flash_host_model.select();
      i_flash_host_model.deselect();
    end
    // reset released in deep sleep restarts the wake wait
    i_flash_host_model.sleep_enter();
    i_flash_host_model.reset_low();
    i_flash_host_model.reset_high();
    i_flash_host_model.sleep_exit();
    @(negedge clock);
    `CHK("reset_woken", 2'b00, {status.asleep, wake_ok})
    wait_sig(3, flash_seq_pkg::WAKE_CYC + 10);
    `CHK("reset_wake_cycles", 1'b1, n >= flash_seq_pkg::WAKE_CYC - 3)
    conclude();
  end
endmodule : flash_op_timing_reset_dpd_tb
